// >>> bench/testbench.sv
// Self-checking testbench for the four-phase envelope generator over APB.
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic        clk_sys;  // System clock.
	logic        nrst;     // Synchronous reset, active low.
	logic        psel;     // APB select.
	logic        penable;  // APB enable.
	logic        pwrite;   // APB write.
	logic [11:0] paddr;    // APB byte address.
	logic [31:0] pwdata;   // APB write data.
	logic [31:0] prdata;   // APB read data.
	logic        pready;   // APB ready.
	logic        pslverr;  // APB error.
	logic [7:0]  envLevel; // Envelope amplitude.
	logic [32:0] expQ [$]; // Expected error flag and read data, oldest first.
	logic [15:0] rnd;      // Random settings word.
	logic [7:0]  lvlSeen;  // Level noted before a gate set and after a gate clear.
	int          n_errors;
	int          comparisons;
	int          cnt;
	int          ex;

	fpe_envelope DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.envLevel(envLevel));

	// Clock of 100 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Next value of the stimulus shift register.
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	// Compares a seen value with its expectation and counts both outcomes.
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		comparisons++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, seen, want);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// One APB transfer; the expectation is queued for the monitor.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] want);
		expQ.push_back(want);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	// Waits for a level, counting cycles up to a limit.
	task automatic wait_lvl(input logic [7:0] t, input int lim);
		cnt = 0;
		while (envLevel !== t && cnt < lim) begin
			@(posedge clk_sys);
			cnt++;
		end
	endtask : wait_lvl

	// Monitor: every completed transfer is matched with the oldest expectation.
	always @(posedge clk_sys) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
			check({pslverr, (pwrite ? 32'h0000_0000 : prdata)}, expQ.pop_front());
	end

	// Watchdog that cuts a hang short.
	initial begin
		repeat (95000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end

	// Main sequence.
	initial begin
		n_errors = 0;
		comparisons = 0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rnd = 16'h2A5A;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, fpe_pkg::ADDR_CTRL, 32'h0, 33'h0_0000_0000);
		apb(1'b0, fpe_pkg::ADDR_RATES, 32'h0, 33'h0_0000_0000);
		apb(1'b0, fpe_pkg::ADDR_STATUS, 32'h0, 33'h0_0000_0300);
		apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
		apb(1'b1, 12'h00C, {rnd, rnd}, 33'h1_0000_0000);
		rnd = lfsr(lfsr(rnd));
		apb(1'b1, fpe_pkg::ADDR_RATES, {16'hFFFF, rnd}, 33'h0);
		apb(1'b0, fpe_pkg::ADDR_RATES, 32'h0, {17'h0, rnd});
		// Attack from zero to peak at setting 0, then decay to sustain 14.
		apb(1'b1, fpe_pkg::ADDR_RATES, 32'h0000_0E00, 33'h0);
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0000_0001, 33'h0);
		wait_lvl(8'hFF, 30000);
		check(33'(cnt > 15000 && cnt < 25000), 33'h1);
		wait_lvl(8'hEE, 8000);
		check(33'(cnt > 2800 && cnt < 8000), 33'h1);
		repeat (600) @(posedge clk_sys);
		check(envLevel, 8'hEE);
		apb(1'b0, fpe_pkg::ADDR_STATUS, 32'h0, 33'h0_0000_02EE);
		// Sustain fifteen, then a short release and a new gate: attack resumes to full level.
		apb(1'b1, fpe_pkg::ADDR_RATES, 32'h0000_0F00, 33'h0);
		check(envLevel, 8'hEE);
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0, 33'h0);
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0000_0001, 33'h0);
		check(33'(envLevel > 8'hE0), 33'h1);
		wait_lvl(8'hFF, 2000);
		check(33'(cnt < 2000), 33'h1);
		repeat (100) @(posedge clk_sys);
		apb(1'b0, fpe_pkg::ADDR_STATUS, 32'h0, 33'h0_0000_02FF);
		// Release part way, gate again, then clear the gate during attack.
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0, 33'h0);
		repeat (1000) @(posedge clk_sys);
		lvlSeen = envLevel;
		check(33'(lvlSeen < 8'hFF && lvlSeen > 8'h00), 33'h1);
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0000_0001, 33'h0);
		repeat (300) @(posedge clk_sys);
		check(33'(envLevel > lvlSeen), 33'h1);
		apb(1'b1, fpe_pkg::ADDR_CTRL, 32'h0, 33'h0);
		lvlSeen = envLevel;
		repeat (300) @(posedge clk_sys);
		check(33'(envLevel < lvlSeen && envLevel > 8'h00), 33'h1);
		ex = int'(lvlSeen) * 60000 / 255; // Six milliseconds of 100 ns cycles spread over full scale.
		wait_lvl(8'h00, 72000);
		check(33'(cnt > ex * 7 / 10 && cnt < ex * 12 / 10), 33'h1);
		apb(1'b0, fpe_pkg::ADDR_STATUS, 32'h0, 33'h0_0000_0300);
		test_done();
	end
endmodule : testbench

`default_nettype wire

// >>> design/fpe_apb_regs.sv
// APB register slave holding gate and envelope settings.
`timescale 1ns/10ps
`default_nettype none

module fpe_apb_regs (
	input  wire logic                  clk_sys,   // System clock.
	input  wire logic                  nrst,      // Synchronous reset, active low.
	input  wire logic                  psel,      // APB select.
	input  wire logic                  penable,   // APB enable.
	input  wire logic                  pwrite,    // APB write.
	input  wire logic [11:0]           paddr,     // APB byte address.
	input  wire logic [31:0]           pwdata,    // APB write data.
	output logic      [31:0]           prdata,    // APB read data.
	output logic                       pready,    // APB ready.
	output logic                       pslverr,   // APB error.
	input  wire logic [7:0]            level,     // Current amplitude.
	input  wire fpe_pkg::fpe_phase_e   phase,     // Current phase.
	output logic                       gate,      // Note-on control.
	output fpe_pkg::fpe_settings_s     settings   // Rate and level settings.
);

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	logic                   gate_reg;
	logic                   gate_next;
	fpe_pkg::fpe_settings_s set_reg;
	fpe_pkg::fpe_settings_s set_next;
	logic [31:0]            rd_reg;
	logic [31:0]            rd_next;
	logic                   err_reg;
	logic                   err_next;
	logic                   access;
	logic                   commit;

	assign access = psel && !penable;            // Decode in setup, answer in access.
	assign commit = psel && penable && pwrite;   // Writes land at the completing edge.

	// Capture read data and the error flag in setup; commit writes only when the access completes.
	always_comb begin
		gate_next = gate_reg;
		set_next  = set_reg;
		rd_next   = rd_reg;
		err_next  = err_reg;
		if (access) begin
			err_next = 1'b0;
			rd_next  = 32'h0000_0000;
			if (paddr == fpe_pkg::ADDR_CTRL) begin
				rd_next[fpe_pkg::CTRL_GATE_BIT] = gate_reg;
			end else if (paddr == fpe_pkg::ADDR_RATES) begin
				rd_next[15:0] = set_reg;
			end else if (paddr == fpe_pkg::ADDR_STATUS) begin
				rd_next[7:0] = level;
				rd_next[9:8] = phase;
			end else begin
				err_next = 1'b1;
			end
		end
		if (commit) begin
			if (paddr == fpe_pkg::ADDR_CTRL) begin
				gate_next = pwdata[fpe_pkg::CTRL_GATE_BIT];
			end else if (paddr == fpe_pkg::ADDR_RATES) begin
				set_next = pwdata[15:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			gate_reg <= 1'b0;
			set_reg  <= fpe_pkg::RATES_RESET;
			rd_reg   <= 32'h0000_0000;
			err_reg  <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			set_reg  <= set_next;
			rd_reg   <= rd_next;
			err_reg  <= err_next;
		end
	end

	assign pready   = psel && penable;  // One wait-free access cycle.
	assign prdata   = rd_reg;
	assign pslverr  = pready && err_reg;
	assign gate     = gate_reg;
	assign settings = set_reg;

endmodule : fpe_apb_regs
`default_nettype wire

// >>> design/fpe_envelope.sv
// Top level of the four-phase envelope generator with its APB port.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Amplitude passes attack, decay, sustain and release, each with its own setting.
// - Attack raises amplitude from its present value to peak at attack rate.
// - Decay lowers amplitude from peak toward sustain level at decay rate.
// - Release lowers amplitude from present value to zero at release rate.
// - Sustain holds level while gate is set; release starts when gate clears.
// - Sustain zero lets decay fall to zero while gate stays set.
// - Sustain setting fifteen means full volume.
// - Attack setting 0 takes about 2 ms, setting 10 about 500 ms.
// - Decay setting 8 takes about 300 ms, setting 9 about 750 ms.
// - Release setting 0 takes about 6 ms, setting 9 about 750 ms.
// - Gate may change at any time and every change is obeyed.
// - Gate cleared during attack starts release at once from present amplitude.
// - Gate set during release starts attack at once from present amplitude.
module fpe_envelope (
	input  wire logic        clk_sys,  // System clock, 10 MHz.
	input  wire logic        nrst,     // Synchronous reset, active low.
	input  wire logic        psel,     // APB select.
	input  wire logic        penable,  // APB enable.
	input  wire logic        pwrite,   // APB write.
	input  wire logic [11:0] paddr,    // APB byte address.
	input  wire logic [31:0] pwdata,   // APB write data.
	output logic      [31:0] prdata,   // APB read data.
	output logic             pready,   // APB ready.
	output logic             pslverr,  // APB error.
	output logic      [7:0]  envLevel  // Envelope amplitude.
);

	// ----------------------------------------------------------------
	// Register slave and rate timing.
	// ----------------------------------------------------------------
	logic                   gate;
	fpe_pkg::fpe_settings_s settings;
	fpe_pkg::fpe_phase_e    phase_reg;
	fpe_pkg::fpe_phase_e    phase_next;
	logic [7:0]             level_reg;
	logic [7:0]             level_next;
	logic [3:0]             rateSel;
	logic                   stepTick;
	logic [7:0]             sustainLevel;

	fpe_apb_regs u_regs (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.level    (level_reg),
		.phase    (phase_reg),
		.gate     (gate),
		.settings (settings)
	);

	// Choose the rate of the active phase.
	always_comb begin
		case (phase_reg)
			fpe_pkg::FPE_ATTACK:  rateSel = settings.attack_rate;
			fpe_pkg::FPE_DECAY:   rateSel = settings.decay_rate;
			default:              rateSel = settings.release_rate;
		endcase
	end

	// Step interval per rate; decay and release run three times slower.
	fpe_rate_div #(
		.CNT_W (24)
	) u_div (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.rate     (rateSel),
		.slow     (phase_reg != fpe_pkg::FPE_ATTACK),
		.stepTick (stepTick)
	);

	// Sustain nibble repeated to eight bits so fifteen reaches peak.
	assign sustainLevel = {settings.sustain_level, settings.sustain_level};

	// ----------------------------------------------------------------
	// Envelope phase machine.
	// ----------------------------------------------------------------
	// Next phase and amplitude.
	always_comb begin
		phase_next = phase_reg;
		level_next = level_reg;
		case (phase_reg)
			fpe_pkg::FPE_ATTACK: begin
				if (!gate) begin
					phase_next = fpe_pkg::FPE_RELEASE;
				end else if (level_reg == fpe_pkg::LEVEL_PEAK) begin
					phase_next = fpe_pkg::FPE_DECAY;
				end else if (stepTick) begin
					level_next = level_reg + 8'h01;
				end
			end
			fpe_pkg::FPE_DECAY: begin
				if (!gate) begin
					phase_next = fpe_pkg::FPE_RELEASE;
				end else if (level_reg <= sustainLevel) begin
					phase_next = fpe_pkg::FPE_SUSTAIN;
				end else if (stepTick) begin
					level_next = level_reg - 8'h01;
				end
			end
			fpe_pkg::FPE_SUSTAIN: begin
				if (!gate) begin
					phase_next = fpe_pkg::FPE_RELEASE;
				end
			end
			default: begin
				if (gate) begin
					phase_next = fpe_pkg::FPE_ATTACK;
				end else if (stepTick && (level_reg != fpe_pkg::LEVEL_ZERO)) begin
					level_next = level_reg - 8'h01;
				end
			end
		endcase
	end

	// Register phase and amplitude; reset rests in release at zero.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			phase_reg <= fpe_pkg::FPE_RELEASE;
			level_reg <= fpe_pkg::LEVEL_ZERO;
		end else begin
			phase_reg <= phase_next;
			level_reg <= level_next;
		end
	end

	assign envLevel = level_reg;

	// ----------------------------------------------------------------
	// Check helpers: sustain entry level and step spacing.
	// ----------------------------------------------------------------
	logic [7:0] holdLevel_reg;
	logic [7:0] holdLevel_next;
	logic [7:0] gapCnt_reg;
	logic [7:0] gapCnt_next;

	// Remember the level at which sustain was entered, so any drift in sustain shows up.
	always_comb begin
		holdLevel_next = holdLevel_reg;
		if ((phase_next == fpe_pkg::FPE_SUSTAIN) && (phase_reg != fpe_pkg::FPE_SUSTAIN)) begin
			holdLevel_next = level_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			holdLevel_reg <= fpe_pkg::LEVEL_ZERO;
		end else begin
			holdLevel_reg <= holdLevel_next;
		end
	end

	// Count cycles since the last step pulse, saturating so a slow rate cannot wrap it.
	always_comb begin
		gapCnt_next = gapCnt_reg;
		if (stepTick) begin
			gapCnt_next = 8'h00;
		end else if (gapCnt_reg != 8'hFF) begin
			gapCnt_next = gapCnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			gapCnt_reg <= '1;  // Start saturated so the first pulse after reset passes.
		end else begin
			gapCnt_reg <= gapCnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence s_gateDrop;
		!gate && (phase_reg == fpe_pkg::FPE_ATTACK);
	endsequence

	sequence s_gateRise;
		gate && (phase_reg == fpe_pkg::FPE_RELEASE);
	endsequence

	// Gate and level conditions that start the decay and sustain transitions.
	sequence s_decayDrop;
		!gate && (phase_reg == fpe_pkg::FPE_DECAY);
	endsequence

	sequence s_sustainDrop;
		!gate && (phase_reg == fpe_pkg::FPE_SUSTAIN);
	endsequence

	sequence s_decayReach;
		gate && (phase_reg == fpe_pkg::FPE_DECAY) && (level_reg <= sustainLevel);
	endsequence

	a_attack_abort: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_gateDrop |=> (phase_reg == fpe_pkg::FPE_RELEASE) && $stable(level_reg))
		else $error("Attack not aborted into release.");

	a_release_retrigger: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_gateRise |=> (phase_reg == fpe_pkg::FPE_ATTACK) && $stable(level_reg))
		else $error("Release not retriggered into attack.");

	a_sustain_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_SUSTAIN) && gate |=> $stable(level_reg))
		else $error("Sustain level moved.");

	a_attack_rise: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_ATTACK) && gate && stepTick && (level_reg != 8'hFF)
		|=> level_reg == $past(level_reg) + 8'h01)
		else $error("Attack did not step up.");

	a_peak_decay: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_ATTACK) && gate && (level_reg == 8'hFF)
		|=> phase_reg == fpe_pkg::FPE_DECAY)
		else $error("Peak did not enter decay.");

	a_release_fall: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_RELEASE) && !gate && stepTick && (level_reg != 8'h00)
		|=> level_reg == $past(level_reg) - 8'h01)
		else $error("Release did not step down.");

	a_release_floor: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_RELEASE) && !gate && (level_reg == 8'h00) |=> level_reg == 8'h00)
		else $error("Release passed zero.");

	a_full_sustain: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_DECAY) && gate && (settings.sustain_level == 4'hF) && (level_reg == 8'hFF)
		|=> (phase_reg == fpe_pkg::FPE_SUSTAIN) && (level_reg == 8'hFF))
		else $error("Full sustain below peak.");

	a_reset_rest: assert property (@(posedge clk_sys)
		!nrst |=> (level_reg == 8'h00) && (phase_reg == fpe_pkg::FPE_RELEASE))
		else $error("Reset state wrong.");

	// ----------------------------------------------------------------
	// Decay, sustain and timing checks.
	// ----------------------------------------------------------------
	// Gate cleared in decay hands over to release at the reached level.
	a_decay_abort: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_decayDrop |=> (phase_reg == fpe_pkg::FPE_RELEASE) && $stable(level_reg))
		else $error("Decay not aborted into release.");

	// Gate cleared in sustain starts release from the sustain level.
	a_sustain_release: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_sustainDrop |=> (phase_reg == fpe_pkg::FPE_RELEASE) && $stable(level_reg))
		else $error("Sustain not released.");

	// Decay stops at the sustain level, zero included.
	a_decay_settle: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_decayReach |=> (phase_reg == fpe_pkg::FPE_SUSTAIN) && $stable(level_reg))
		else $error("Decay did not settle at sustain.");

	// Each decay step lowers the level by one.
	a_decay_fall: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_DECAY) && gate && stepTick && (level_reg > sustainLevel)
		|=> level_reg == $past(level_reg) - 8'h01)
		else $error("Decay did not step down.");

	// The level in sustain is the level at which sustain was entered.
	a_sustain_entry: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_SUSTAIN) |-> level_reg == holdLevel_reg)
		else $error("Sustain level drifted.");

	// No step comes sooner than the fastest attack rate allows.
	a_step_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
		stepTick |-> int'(gapCnt_reg) >= (fpe_pkg::ATTACK_US[0] * fpe_pkg::CLK_MHZ / fpe_pkg::STEPS_FULL))
		else $error("Step interval too short.");

	// A step pulse lasts one cycle.
	a_step_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
		stepTick |=> !stepTick)
		else $error("Step pulse too long.");

	// The level moves by at most one step per cycle in any phase.
	a_level_slew: assert property (@(posedge clk_sys) disable iff (!nrst)
		(level_reg == $past(level_reg)) || (level_reg == $past(level_reg) + 8'h01)
		|| (level_reg == $past(level_reg) - 8'h01))
		else $error("Level jumped.");

	// The level holds at peak while attack hands over to decay.
	a_peak_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_ATTACK) && gate && (level_reg == 8'hFF) |=> $stable(level_reg))
		else $error("Peak not held.");

	// Release moves the level only on a step.
	a_release_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_RELEASE) && !gate && !stepTick |=> $stable(level_reg))
		else $error("Release moved without a step.");

	// Sustain lasts as long as the gate stays set.
	a_sustain_stay: assert property (@(posedge clk_sys) disable iff (!nrst)
		(phase_reg == fpe_pkg::FPE_SUSTAIN) && gate |=> phase_reg == fpe_pkg::FPE_SUSTAIN)
		else $error("Sustain left with gate set.");

endmodule : fpe_envelope
`default_nettype wire

// >>> design/fpe_pkg.sv
// Constants and carrier types for the four-phase envelope generator.
package fpe_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on APB).
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_RATES  = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int          CTRL_GATE_BIT   = 0;
	localparam int          RATE_ATK_LSB    = 0;
	localparam int          RATE_DEC_LSB    = 4;
	localparam int          RATE_SUS_LSB    = 8;
	localparam int          RATE_REL_LSB    = 12;
	localparam logic [15:0] RATES_RESET     = 16'h0000;
	localparam logic [7:0]  LEVEL_PEAK      = 8'hFF;
	localparam logic [7:0]  LEVEL_ZERO      = 8'h00;

	// ----------------------------------------------------------------
	// Timing: the attack time per rate setting, in microseconds.
	// Decay and release take three times the attack time.
	// ----------------------------------------------------------------
	localparam int CLK_MHZ    = 10;
	localparam int STEPS_FULL = 255;
	localparam int DECAY_MULT = 3;
	localparam int ATTACK_US [16] = '{2000, 8000, 16000, 24000, 38000, 56000, 68000, 80000,
	                                  100000, 250000, 500000, 800000, 1000000, 3000000,
	                                  5000000, 8000000};

	// Envelope phases.
	typedef enum logic [1:0] {
		FPE_ATTACK,
		FPE_DECAY,
		FPE_SUSTAIN,
		FPE_RELEASE
	} fpe_phase_e;

	// Rate and level settings carried together.
	typedef struct packed {
		logic [3:0] release_rate;
		logic [3:0] sustain_level;
		logic [3:0] decay_rate;
		logic [3:0] attack_rate;
	} fpe_settings_s;

endpackage : fpe_pkg

// >>> design/fpe_rate_div.sv
// Rate prescaler that emits one step pulse per programmed interval.
`timescale 1ns/10ps
`default_nettype none

module fpe_rate_div #(
	parameter int CNT_W = 24
) (
	input  wire logic       clk_sys,  // System clock.
	input  wire logic       nrst,     // Synchronous reset, active low.
	input  wire logic [3:0] rate,     // Selected rate setting.
	input  wire logic       slow,     // High for decay and release timing.
	output logic            stepTick  // One-cycle step pulse.
);

	// ----------------------------------------------------------------
	// Period lookup and counter.
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] period;

	// Convert the rate time into clock cycles per amplitude step.
	always_comb begin
		int mult;
		mult = slow ? fpe_pkg::DECAY_MULT : 1;
		period = CNT_W'((fpe_pkg::ATTACK_US[rate] * fpe_pkg::CLK_MHZ * mult) / fpe_pkg::STEPS_FULL);
	end

	// Count down and reload on each step.
	always_comb begin
		cnt_next = cnt_reg - 1'b1;
		if ((cnt_reg == '0) || (cnt_reg > period)) begin
			cnt_next = period;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign stepTick = (cnt_reg == '0);  // Step when the interval expires.

endmodule : fpe_rate_div
`default_nettype wire
